/* hdl/phase_cmd_decoder.sv */
/*
 * Listener end: recognises its listen address and decodes terminated commands.
 * Assumes the controller keeps the address, terminator and ATN discipline.
 */
`timescale 1ns/1ps
`include "phase_cmd_cfg.svh"
module phase_cmd_decoder #(
    parameter logic [4:0]            BUS_ADDR = 5'h0d,
    parameter phase_cmd_pkg::variant_e VARIANT = phase_cmd_pkg::VARIANT_FINE
) (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        srst,
    // Bus link.
    gpib_link_if.listener    bus,
    // Instrument settings.
    output logic [35:0]      freq_bcd,
    output logic [3:0]       atten_db,
    output logic [15:0]      phase_steps,
    output logic             remote,
    output logic             update
);
    // ==========================================================
    // Byte intake
    // ==========================================================
    logic                addressed_r;
    phase_cmd_pkg::cmd_e cmd_r;
    logic                soh_r;
    logic [35:0]         acc_r;
    logic                take;
    logic [7:0]          ch;
    logic [7:0]          up;
    logic [3:0]          nib;
    logic                is_digit;
    logic                is_hex;
    logic                is_term;
    logic                is_soh;
    logic                is_freq_letter;
    logic                is_level_letter;
    logic                is_phase_letter;
    logic                is_letter;
    logic                cmd_byte;
    logic                data_byte;

    // The listener never stalls, so every strobe is one taken byte.
    assign bus.rfd         = 1'b1;
    assign take            = bus.dav && bus.rfd;
    assign ch              = bus.dio;
    // Clearing the case bit folds lower-case letters onto upper case; no digit folds onto a letter.
    assign up              = ch & ~`CASE_BIT;
    assign is_digit        = (ch >= `CH_ZERO) && (ch <= `CH_NINE);
    assign is_hex          = (ch >= `CH_ZERO) && (ch <= `CH_HEX_LAST);
    assign is_term         = (ch == `CH_LF) || (ch == `CH_CR);
    assign is_soh          = (ch == `CH_SOH);
    assign is_freq_letter  = (up == `CH_F);
    assign is_level_letter = (up == `CH_A);
    assign is_phase_letter = (up == `CH_D);
    assign is_letter       = is_freq_letter || is_level_letter || is_phase_letter;
    // The substitute characters carry the values 10 to 15 in their low nibble, as the digits carry 0 to 9.
    assign nib             = ch[3:0];
    assign cmd_byte        = take && bus.atn;
    assign data_byte       = take && !bus.atn && addressed_r;

    // ==========================================================
    // Listener addressing
    // ==========================================================
    logic [7:0] my_listen;

    assign my_listen = `LISTEN_BASE | {3'h0, BUS_ADDR};

    // Another device's listen address leaves this one addressed, as on a shared bus.
    always_ff @(posedge clk) begin
        if (srst) begin
            addressed_r <= 1'b0;
        end else if (cmd_byte && (ch == my_listen)) begin
            addressed_r <= 1'b1;
        end else if (cmd_byte && (ch == `UNLISTEN)) begin
            addressed_r <= 1'b0;
        end
    end

    // ==========================================================
    // Command accumulation
    // ==========================================================
    phase_cmd_pkg::cmd_e cmd_nxt;
    logic                digit_ok;

    // A later letter overrides an earlier one, so only one command survives per string.
    always_comb begin
        cmd_nxt = phase_cmd_pkg::CMD_NONE;
        if (is_freq_letter) begin
            cmd_nxt = phase_cmd_pkg::CMD_FREQ;
        end else if (is_level_letter) begin
            cmd_nxt = phase_cmd_pkg::CMD_LEVEL;
        end else if (is_phase_letter) begin
            cmd_nxt = phase_cmd_pkg::CMD_PHASE;
        end
    end

    // Substitute characters count as digits only inside a phase argument; anything else is dropped.
    assign digit_ok = is_digit || (is_hex && (cmd_r == phase_cmd_pkg::CMD_PHASE));

    always_ff @(posedge clk) begin
        if (srst) begin
            cmd_r <= phase_cmd_pkg::CMD_NONE;
        end else if (data_byte && is_term) begin
            cmd_r <= phase_cmd_pkg::CMD_NONE;
        end else if (data_byte && is_letter) begin
            cmd_r <= cmd_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            soh_r <= 1'b0;
        end else if (data_byte && is_term) begin
            soh_r <= 1'b0;
        end else if (data_byte && is_soh) begin
            soh_r <= 1'b1;
        end
    end

    // Digits shift in from the right, so a short argument leaves leading zeros.
    always_ff @(posedge clk) begin
        if (srst) begin
            acc_r <= 36'h0;
        end else if (data_byte && (is_term || is_letter)) begin
            acc_r <= 36'h0;
        end else if (data_byte && digit_ok) begin
            acc_r <= {acc_r[31:0], nib};
        end
    end

    // ==========================================================
    // Phase digit weighting
    // ==========================================================
    // The base variant gives its two lower digits no weight; they must be sent as zeros.
    localparam logic [15:0] W_BASE   [`PHASE_DIGITS] = '{`W90_COARSE, 16'h0000, 16'h0000};
    localparam logic [15:0] W_OPTION [`PHASE_DIGITS] = '{`W90_COARSE, `W50_COARSE, `W5_COARSE};
    localparam logic [15:0] W_FINE   [`PHASE_DIGITS] = '{`W22_FINE, `W2_FINE, `W0_FINE};
    logic [3:0]  digit  [`PHASE_DIGITS];
    logic [3:0]  value  [`PHASE_DIGITS];
    logic [15:0] weight [`PHASE_DIGITS];
    logic [15:0] part   [`PHASE_DIGITS];
    logic [15:0] phase_nxt;

    // Index 0 is the most significant phase digit.
    for (genvar k = 0; k < `PHASE_DIGITS; k++) begin : g_digit
        assign digit[k]  = acc_r[4*(`PHASE_DIGITS-1-k) +: 4];
        assign value[k]  = (VARIANT == phase_cmd_pkg::VARIANT_BASE) ?
                           ((digit[k] ^ `HEX_ALL_ONES) & `BASE_STEP_MASK) : digit[k];
        assign weight[k] = (VARIANT == phase_cmd_pkg::VARIANT_BASE)   ? W_BASE[k]   :
                           (VARIANT == phase_cmd_pkg::VARIANT_OPTION) ? W_OPTION[k] :
                                                                        W_FINE[k];
        assign part[k]   = 16'(value[k]) * weight[k];
    end
    assign phase_nxt = part[0] + part[1] + part[2];

    // ==========================================================
    // Settings update on terminator
    // ==========================================================
    logic exec;
    logic go_local;
    logic is_freq;
    logic is_level;
    logic is_phase;
    logic exec_set;

    assign exec     = data_byte && is_term;
    // Only the bare SOH string leaves remote, so a stray SOH inside a command is harmless.
    assign go_local = exec && soh_r && (cmd_r == phase_cmd_pkg::CMD_NONE);
    assign is_freq  = exec && (cmd_r == phase_cmd_pkg::CMD_FREQ);
    assign is_level = exec && (cmd_r == phase_cmd_pkg::CMD_LEVEL);
    assign is_phase = exec && (cmd_r == phase_cmd_pkg::CMD_PHASE);
    assign exec_set = is_freq || is_level || is_phase;

    always_ff @(posedge clk) begin
        if (srst) begin
            freq_bcd <= 36'h0;
        end else if (is_freq) begin
            freq_bcd <= acc_r;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            atten_db <= 4'h0;
        end else if (is_level) begin
            atten_db <= acc_r[3:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            phase_steps <= 16'h0;
        end else if (is_phase) begin
            phase_steps <= phase_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            remote <= 1'b1;
        end else if (go_local) begin
            remote <= 1'b0;
        end else if (exec_set) begin
            remote <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            update <= 1'b0;
        end else begin
            update <= exec_set;
        end
    end
endmodule

/* hdl/phase_cmd_cfg.svh */
/*
 * Constants for the bus-side command decoder and the bus controller end.
 * Assumes a single clock and a synchronous active-high reset.
 */
// Summary of operation
// - Base variant: inverted first digit, 90 degree steps.
// - Optional phase: 90, 50, 5 degree digit sum.
// - Fine variant: 22.5, 2.25, 0.225 degree digit sum.
// - Listen address is 32 plus switch address.
// - Controller sends address, data, LF, unlisten.
// - Controller terminates every command with LF.
// - SOH then terminator returns to local control.
// - A plus digit sets attenuation in dB.
// - F plus nine digits sets frequency in Hz.
// - Controller drives ATN, not the command text.
// - Codes 58 to 63 mean digits 10-15 in a phase argument only.
// - Unrecognised characters are silently discarded.
// - Only terminator executes; one command per string.
// - Missing digits are taken as leading zeros.
`ifndef PHASE_CMD_CFG_SVH
`define PHASE_CMD_CFG_SVH
`define CH_SOH        8'h01
`define CH_LF         8'h0a
`define CH_CR         8'h0d
`define CH_ZERO       8'h30
`define CH_NINE       8'h39
`define CH_HEX_LAST   8'h3f
`define CH_A          8'h41
`define CH_D          8'h44
`define CH_F          8'h46
`define CASE_BIT      8'h20
`define LISTEN_BASE   8'h20
`define UNLISTEN      8'h3f
`define FREQ_DIGITS   9
`define PHASE_DIGITS  3
// Phase weights in units of 0.225 degree for the fine variant and 5 degrees otherwise.
`define W90_COARSE    16'h0012
`define W50_COARSE    16'h000a
`define W5_COARSE     16'h0001
`define W22_FINE      16'h0064
`define W2_FINE       16'h000a
`define W0_FINE       16'h0001
`define HEX_ALL_ONES  4'hf
`define BASE_STEP_MASK 4'h3
`endif

/* hdl/phase_cmd_pkg.sv */
/*
 * Shared types for the command decoder and its bench.
 * Assumes phase_cmd_cfg.svh is available on the include path.
 */
package phase_cmd_pkg;
    typedef enum logic [1:0] {
        VARIANT_BASE   = 2'h0,
        VARIANT_OPTION = 2'h1,
        VARIANT_FINE   = 2'h2
    } variant_e;
    typedef enum logic [1:0] {
        CMD_NONE  = 2'h0,
        CMD_FREQ  = 2'h1,
        CMD_LEVEL = 2'h3,
        CMD_PHASE = 2'h2
    } cmd_e;
endpackage

/* hdl/gpib_link_if.sv */
/*
 * Byte-wide handshake link between the bus controller and the listener.
 * Assumes both ends share clk; a byte moves when dav and rfd are both high.
 */
`timescale 1ns/1ps
interface gpib_link_if;
    logic [7:0] dio;
    logic       atn;
    logic       dav;
    logic       rfd;
    modport controller (output dio, output atn, output dav, input rfd);
    modport listener   (input dio, input atn, input dav, output rfd);
endinterface

/* hdl/gpib_cmd_controller.sv */
/*
 * Controller end: sends one command string framed as address, data, LF, unlisten.
 * Assumes the user holds the string stable while busy is high.
 */
`timescale 1ns/1ps
`include "phase_cmd_cfg.svh"
module gpib_cmd_controller #(
    parameter int MAX_LEN = 12
) (
    // Clock and reset.
    input  wire logic                 clk,
    input  wire logic                 srst,
    // User request.
    input  wire logic                 start,
    input  wire logic [4:0]           dev_addr,
    input  wire logic [MAX_LEN*8-1:0] text,
    input  wire logic [3:0]           text_len,
    output logic                      busy,
    // Bus link.
    gpib_link_if.controller           bus
);
    // ==========================================================
    // Framing sequencer
    // ==========================================================
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_DATA = 3'h3,
        ST_TERM = 3'h2,
        ST_UNL  = 3'h6
    } state_e;
    state_e     state_r;
    logic [3:0] idx_r;
    logic       go;

    assign go   = bus.rfd;
    assign busy = (state_r != ST_IDLE);

    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= ST_IDLE;
            idx_r   <= 4'h0;
        end else begin
            case (state_r)
                ST_IDLE: if (start) begin
                    state_r <= ST_ADDR;
                    idx_r   <= 4'h0;
                end
                ST_ADDR: if (go) state_r <= (text_len == 4'h0) ? ST_TERM : ST_DATA;
                ST_DATA: if (go) begin
                    idx_r <= idx_r + 4'h1;
                    if (idx_r + 4'h1 == text_len) state_r <= ST_TERM;
                end
                ST_TERM: if (go) state_r <= ST_UNL;
                ST_UNL:  if (go) state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // ATN and the address, LF and unlisten bytes come from the sequencer; only data bytes come from the user text.
    always_comb begin
        bus.dav = busy;
        bus.atn = 1'b0;
        bus.dio = 8'h00;
        case (state_r)
            ST_ADDR: begin
                bus.atn = 1'b1;
                bus.dio = `LISTEN_BASE | {3'h0, dev_addr};
            end
            ST_DATA: bus.dio = text[idx_r*8 +: 8];
            ST_TERM: bus.dio = `CH_LF;
            ST_UNL: begin
                bus.atn = 1'b1;
                bus.dio = `UNLISTEN;
            end
            default: begin
            end
        endcase
    end
endmodule

/* verification/phase_cmd_chk.sv */
/* Checker on the controller-to-listener link and the listener's settings.
   Assumes clk and srst are shared by both ends and the link. */
`timescale 1ns/1ps
module phase_cmd_chk (
    // Clock and reset.
    input wire logic        clk,
    input wire logic        srst,
    // Link.
    input wire logic [7:0]  dio,
    input wire logic        atn,
    input wire logic        dav,
    input wire logic        rfd,
    // Settings.
    input wire logic [35:0] freq_bcd,
    input wire logic [3:0]  atten_db,
    input wire logic [15:0] phase_steps,
    input wire logic        remote,
    input wire logic        update
);
    // The edge after reset is skipped too, since $past there still sees values from before the reset.
    logic srst_d_r;
    always_ff @(posedge clk) begin
        srst_d_r <= srst;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst || srst_d_r);
    // =========================================================
    // Link framing.
    property p_addr; dav && rfd && atn |-> dio[7:5] == 3'h1; endproperty
    a_addr: assert property (p_addr) else $error("address byte out of range");
    property p_unl; dav && atn && dio == 8'h3f |-> $past(dio) == 8'h0a && !$past(atn); endproperty
    a_unl: assert property (p_unl) else $error("unlisten not after LF");
    // =========================================================
    // Execution. Outputs move only on a terminator, so a stray edge is caught.
    property p_cause; update |-> $past(dav && !atn && (dio == 8'h0a || dio == 8'h0d)); endproperty
    a_cause: assert property (p_cause) else $error("update without terminator");
    property p_pulse; update |=> !update; endproperty
    a_pulse: assert property (p_pulse) else $error("update too long");
    property p_hold; !update |-> $stable(freq_bcd) && $stable(atten_db) && $stable(phase_steps); endproperty
    a_hold: assert property (p_hold) else $error("setting moved without update");
    property p_local; $fell(remote) |-> $past(dio, 2) == 8'h01; endproperty
    a_local: assert property (p_local) else $error("local without SOH");
    property p_atten; update |-> atten_db <= 4'h9; endproperty
    a_atten: assert property (p_atten) else $error("attenuation above one digit");
    property p_phase; update |-> phase_steps <= 16'h063f; endproperty
    a_phase: assert property (p_phase) else $error("phase beyond fine range");
endmodule

/* verification/tb.sv */
/* Self-checking bench: controller end drives the listener over one link.
   Assumes the main listener is the fine variant at listen address 45 (switch address 13); two more cover the other variants. */
`timescale 1ns/1ps
module tb;
    typedef struct {
        logic [4:0]  a;
        string       s;
        logic [35:0] f;
        logic [3:0]  d;
        logic [15:0] p;
    } row_s;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        start = 1'b0;
    logic [4:0]  dev_addr = 5'h0d;
    logic [95:0] text = '0;
    logic [3:0]  text_len = 4'h0;
    logic        busy;
    logic [35:0] freq_bcd;
    logic [3:0]  atten_db;
    logic [15:0] phase_steps;
    logic        remote;
    logic        update;
    int          n_mismatch = 0;
    int          num_checks = 0;
    row_s        rows[9] = '{
        '{5'h0d, "F123456789", 36'h123456789, 4'h0, 16'h0000},
        '{5'h0d, "A3", 36'h123456789, 4'h3, 16'h0000},
        '{5'h0d, "D400", 36'h123456789, 4'h3, 16'h0190},
        '{5'h0d, "D<00", 36'h123456789, 4'h3, 16'h04b0},
        '{5'h0d, "D>45", 36'h123456789, 4'h3, 16'h05a5},
        '{5'h0d, "F12", 36'h000000012, 4'h3, 16'h05a5},
        '{5'h0d, "a5", 36'h000000012, 4'h5, 16'h05a5},
        '{5'h0d, "d1,2", 36'h000000012, 4'h5, 16'h000c},
        '{5'h0c, "A7", 36'h000000012, 4'h5, 16'h000c}};
    gpib_link_if link ();
    gpib_cmd_controller gpib_cmd_controller_inst (.clk(clk), .srst(srst), .start(start), .dev_addr(dev_addr),
        .text(text), .text_len(text_len), .busy(busy), .bus(link));
    phase_cmd_decoder phase_cmd_decoder_inst (.clk(clk), .srst(srst), .bus(link), .freq_bcd(freq_bcd),
        .atten_db(atten_db), .phase_steps(phase_steps), .remote(remote), .update(update));
    phase_cmd_chk phase_cmd_chk_inst (.clk(clk), .srst(srst), .dio(link.dio), .atn(link.atn), .dav(link.dav),
        .rfd(link.rfd), .freq_bcd(freq_bcd), .atten_db(atten_db), .phase_steps(phase_steps),
        .remote(remote), .update(update));
    // Listeners of the base and option variants watch the same traffic on copies of the link.
    for (genvar v = 0; v < 2; v++) begin : g_alt
        logic [15:0] phase_alt;
        gpib_link_if link_alt ();
        assign link_alt.dio = link.dio;
        assign link_alt.atn = link.atn;
        assign link_alt.dav = link.dav;
        phase_cmd_decoder #(.VARIANT(phase_cmd_pkg::variant_e'(v))) phase_cmd_decoder_inst (.clk(clk),
            .srst(srst), .bus(link_alt), .freq_bcd(), .atten_db(), .phase_steps(phase_alt), .remote(),
            .update());
    end
    always #5 clk = ~clk;
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string w);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h want %h", $time, w, got, exp);
        end
    endtask
    // =========================================================
    // One whole command per call; the controller adds LF and unlisten.
    task automatic send(input logic [4:0] a, input string s);
        int          n;
        logic [95:0] t;
        n = 0;
        t = '0;
        for (int i = 0; i < s.len(); i++) begin
            t[8*i+:8] = s[i];
        end
        @(posedge clk);
        start <= 1'b1;
        dev_addr <= a;
        text <= t;
        text_len <= 4'(s.len());
        @(posedge clk);
        start <= 1'b0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (busy !== 1'b0 && n < 100);
        if (n >= 100) begin
            n_mismatch++;
            $display("mismatch at %0t: controller hung", $time);
            end_sim();
        end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        chk({35'h0, remote}, 36'h1, "reset remote");
        foreach (rows[i]) begin
            send(rows[i].a, rows[i].s);
            chk(freq_bcd, rows[i].f, "freq");
            chk({32'h0, atten_db}, {32'h0, rows[i].d}, "atten");
            chk({20'h0, phase_steps}, {20'h0, rows[i].p}, "phase");
        end
        send(5'h0d, "D311");
        chk({20'h0, g_alt[1].phase_alt}, 36'h41, "option phase");
        chk({20'h0, g_alt[0].phase_alt}, 36'h0, "base phase zero");
        chk({20'h0, phase_steps}, 36'h137, "fine phase");
        send(5'h0d, "D>00");
        chk({20'h0, g_alt[0].phase_alt}, 36'h12, "base phase");
        send(5'h0d, "\001");
        chk({35'h0, remote}, 36'h0, "local");
        chk(freq_bcd, 36'h12, "freq kept");
        send(5'h0d, "F1.5");
        chk({35'h0, remote}, 36'h1, "remote again");
        chk(freq_bcd, 36'h15, "freq dots");
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        #1;
        chk(freq_bcd, 36'h0, "reset freq");
        chk({32'h0, atten_db}, 36'h0, "reset atten");
        end_sim();
    end
endmodule
